// ==== design/port_io_banks.sv ====
// Port logic: drive modes, latches, pin reads, edge interrupts, pull-ups
//
// Behaviour
// - Low-port mode bit: zero open-drain, one push-pull
// - Serial pins forced open-drain when assigned
// - Latch write: zero pulls low, one per mode
// - Normal data read returns pin levels
// - Read-modify-write read returns latch contents
// - Selected edge sets sticky pending flag
// - Polarity bit: zero falling, one rising
// - Unused flag bits read zero, ignore writes
// - High-port mode bit covers four pins
// - Mode bits map port7 high down port4 low
// - Push-pull drives both levels, open-drain releases
// - Pull-ups on after reset, global disable
// - Pull-up off on pins driving low
// - Memory interface owns pins during moves
// - Port4 latch drives pins, reads pins
// - Port4 pins carry write, read, ALE
// - Port3 carries address/data byte for memory
`timescale 1ns/1ps
module port_io_banks #(
    parameter int PORT_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // Register bus
    input  wire port_io_pkg::sfr_req_t sfrReq,
    output logic [7:0]                 sfrRdData,
    // Peripheral open-drain forcing from the crossbar
    input  wire logic [7:0]            port2ForceOd,
    input  wire logic [7:0]            port3ForceOd,
    // External memory interface
    input  wire port_io_pkg::mem_if_t  memIf,
    // Port pins
    input  wire logic [7:0]            port2In,
    output logic [7:0]                 port2Out,
    output logic [7:0]                 port2Oe,
    output logic [7:0]                 port2PullupEn,
    input  wire logic [7:0]            port3In,
    output logic [7:0]                 port3Out,
    output logic [7:0]                 port3Oe,
    output logic [7:0]                 port3PullupEn,
    input  wire logic [7:0]            port4In,
    output logic [7:0]                 port4Out,
    output logic [7:0]                 port4Oe,
    output logic [7:0]                 port4PullupEn,
    // Interrupt requests and crossbar control readback
    output logic                       edgeIrqA,
    output logic                       edgeIrqB,
    output logic                       lowPortStrobeEnable,
    // Port2 latch is kept outside; it is only driven here
    input  wire logic [7:0]            port2LatchIn
);

    port_io_pkg::port_state_t stateReg;
    port_io_pkg::port_state_t stateNext;

    logic [7:0] port2PinSync1;
    logic [7:0] port2PinSync2;
    logic [7:0] port3PinSync1;
    logic [7:0] port3PinSync2;
    logic [7:0] port4PinSync1;
    logic [7:0] port4PinSync2;
    logic [7:0] port4Mode;
    logic [7:0] port3Drive;
    logic [7:0] port4Drive;
    logic [7:0] port2Push;
    logic [7:0] port3Push;
    logic [7:0] port4Push;
    logic [1:0] edgeSeen;
    logic       pullupOff;
    logic       wrFlags;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port2PinSync1 <= 8'h00;
            port2PinSync2 <= 8'h00;
            port3PinSync1 <= 8'h00;
            port3PinSync2 <= 8'h00;
            port4PinSync1 <= 8'h00;
            port4PinSync2 <= 8'h00;
        end else begin
            port2PinSync1 <= port2In;
            port2PinSync2 <= port2PinSync1;
            port3PinSync1 <= port3In;
            port3PinSync2 <= port3PinSync1;
            port4PinSync1 <= port4In;
            port4PinSync2 <= port4PinSync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive computation
    // one mode bit per nibble
    // port4 uses the two lowest bits
    assign port4Mode = {{4{stateReg.nibbleMode[1]}}, {4{stateReg.nibbleMode[0]}}};

    always_comb begin
        port3Drive = stateReg.port3Latch;
        port4Drive = stateReg.port4Latch;
        if (memIf.active) begin
            port3Drive = memIf.dataOut;
            port4Drive[port_io_pkg::MEM_WR_PIN] = memIf.wrStrobe;
            port4Drive[port_io_pkg::MEM_RD_PIN] = memIf.rdStrobe;
            if (memIf.aleUsed) begin
                port4Drive[port_io_pkg::MEM_ALE_PIN] = memIf.aleStrobe;
            end
        end
    end

    // mode bit picks push-pull per pin, per nibble on port4
    assign port2Push = stateReg.port2Mode & ~port2ForceOd;
    assign port3Push = stateReg.port3Mode & ~port3ForceOd;
    assign port4Push = port4Mode;

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs
    // zero pulls low except on port3 during memory reads, one only in push-pull
    // port4 latch appears on the pins, except the memory strobe pins during moves
    always_comb begin
        port2Out = port2LatchIn;
        port2Oe  = ~port2LatchIn | port2Push;
        port3Out = port3Drive;
        port3Oe  = ~port3Drive | port3Push;
        // reads release the data bus drivers
        if (memIf.active && memIf.readCycle) begin
            port3Oe = 8'h00;
        end
        port4Out = port4Drive;
        port4Oe  = ~port4Drive | port4Push;
    end

    // pull-up off where pin driven low
    assign pullupOff     = stateReg.crossbar2[port_io_pkg::PULLUP_DISABLE_BIT];
    assign port2PullupEn = {8{~pullupOff}} & ~(port2Oe & ~port2Out);
    assign port3PullupEn = {8{~pullupOff}} & ~(port3Oe & ~port3Out);
    assign port4PullupEn = {8{~pullupOff}} & ~(port4Oe & ~port4Out);

    ////////////////////////////////////////////////////////////////////////////
    // Register file and interrupt flags
    assign wrFlags = sfrReq.wrEn && (sfrReq.addr == port_io_pkg::EXT_IRQ_FLAGS_ADDR);

    always_comb begin
        stateNext = stateReg;
        // two-stage sync of the interrupt pins
        stateNext.sync1    = {port3In[port_io_pkg::IRQ_B_PIN], port3In[port_io_pkg::IRQ_A_PIN]};
        stateNext.sync2    = stateReg.sync1;
        stateNext.syncPrev = stateReg.sync2;
        edgeSeen[1] = stateReg.irqFlags[port_io_pkg::IRQ_B_POLARITY_BIT]
                    ? (stateReg.sync2[1] & ~stateReg.syncPrev[1])
                    : (~stateReg.sync2[1] & stateReg.syncPrev[1]);
        edgeSeen[0] = stateReg.irqFlags[port_io_pkg::IRQ_A_POLARITY_BIT]
                    ? (stateReg.sync2[0] & ~stateReg.syncPrev[0])
                    : (~stateReg.sync2[0] & stateReg.syncPrev[0]);

        if (sfrReq.wrEn) begin
            if (sfrReq.addr == port_io_pkg::PORT4_LATCH_ADDR) begin
                stateNext.port4Latch = sfrReq.wrData;
            end else if (sfrReq.addr == port_io_pkg::PORT2_DRIVE_MODE_ADDR) begin
                stateNext.port2Mode = sfrReq.wrData;
            end else if (sfrReq.addr == port_io_pkg::PORT3_DRIVE_MODE_ADDR) begin
                stateNext.port3Mode = sfrReq.wrData;
            end else if (sfrReq.addr == port_io_pkg::EXT_IRQ_FLAGS_ADDR) begin
                stateNext.irqFlags = sfrReq.wrData & port_io_pkg::FLAGS_IMPL_MASK;
            end else if (sfrReq.addr == port_io_pkg::PORT3_LATCH_ADDR) begin
                stateNext.port3Latch = sfrReq.wrData;
            end else if (sfrReq.addr == port_io_pkg::HIGH_NIBBLE_MODE_ADDR) begin
                stateNext.nibbleMode = sfrReq.wrData;
            end else if (sfrReq.addr == port_io_pkg::CROSSBAR_CTRL2_ADDR) begin
                stateNext.crossbar2 = sfrReq.wrData;
            end
        end
        // edge sets sticky flag, wins over clear
        if (edgeSeen[1]) begin
            stateNext.irqFlags[port_io_pkg::IRQ_B_PENDING_BIT] = 1'b1;
        end
        if (edgeSeen[0]) begin
            stateNext.irqFlags[port_io_pkg::IRQ_A_PENDING_BIT] = 1'b1;
        end

        // Read data; port latch registers give latch on read-modify-write, pins otherwise
        stateNext.rdData = 8'h00;
        if (sfrReq.rdEn) begin
            if (sfrReq.addr == port_io_pkg::PORT4_LATCH_ADDR) begin
                stateNext.rdData = sfrReq.rmwRead ? stateReg.port4Latch : port4PinSync2;
            end else if (sfrReq.addr == port_io_pkg::PORT2_DRIVE_MODE_ADDR) begin
                stateNext.rdData = stateReg.port2Mode;
            end else if (sfrReq.addr == port_io_pkg::PORT3_DRIVE_MODE_ADDR) begin
                stateNext.rdData = stateReg.port3Mode;
            end else if (sfrReq.addr == port_io_pkg::EXT_IRQ_FLAGS_ADDR) begin
                stateNext.rdData = stateReg.irqFlags & port_io_pkg::FLAGS_IMPL_MASK;
            end else if (sfrReq.addr == port_io_pkg::PORT3_LATCH_ADDR) begin
                stateNext.rdData = sfrReq.rmwRead ? stateReg.port3Latch : port3PinSync2;
            end else if (sfrReq.addr == port_io_pkg::HIGH_NIBBLE_MODE_ADDR) begin
                stateNext.rdData = stateReg.nibbleMode;
            end else if (sfrReq.addr == port_io_pkg::CROSSBAR_CTRL2_ADDR) begin
                stateNext.rdData = stateReg.crossbar2;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg.port2Mode  <= port_io_pkg::MODE_RESET;
            stateReg.port3Mode  <= port_io_pkg::MODE_RESET;
            stateReg.port3Latch <= port_io_pkg::LATCH_RESET;
            stateReg.port4Latch <= port_io_pkg::LATCH_RESET;
            stateReg.nibbleMode <= port_io_pkg::MODE_RESET;
            stateReg.irqFlags   <= port_io_pkg::FLAGS_RESET;
            stateReg.crossbar2  <= port_io_pkg::CROSSBAR_RESET;
            stateReg.sync1      <= 2'b11;
            stateReg.sync2      <= 2'b11;
            stateReg.syncPrev   <= 2'b11;
            stateReg.rdData     <= 8'h00;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign sfrRdData           = stateReg.rdData;
    assign edgeIrqB            = stateReg.irqFlags[port_io_pkg::IRQ_B_PENDING_BIT];
    assign edgeIrqA            = stateReg.irqFlags[port_io_pkg::IRQ_A_PENDING_BIT];
    assign lowPortStrobeEnable = stateReg.crossbar2[port_io_pkg::LOW_STROBE_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_irq_b_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
        edgeSeen[1] |=> edgeIrqB)
        else $error("Pending flag B not set after edge");

    a_irq_a_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
        edgeSeen[0] |=> edgeIrqA)
        else $error("Pending flag A not set after edge");

    a_irq_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (edgeIrqB && !wrFlags) |=> edgeIrqB)
        else $error("Pending flag dropped without a write");

    a_falling_edge: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!stateReg.irqFlags[port_io_pkg::IRQ_A_POLARITY_BIT] && stateReg.syncPrev[0]
         && !stateReg.sync2[0]) |=> edgeIrqA)
        else $error("Falling edge missed on interrupt A");

    a_unused_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (stateReg.irqFlags & ~port_io_pkg::FLAGS_IMPL_MASK) == 8'h00)
        else $error("Unused flag bits not zero");

    a_od_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!memIf.active && !stateReg.port3Mode[0] && stateReg.port3Latch[0]) |-> !port3Oe[0])
        else $error("Open-drain one still drives");

    a_low_drives: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!memIf.active && !stateReg.port4Latch[2]) |-> (port4Oe[2] && !port4Out[2]))
        else $error("Latch zero does not drive low");

    a_force_od: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (port2ForceOd[3] && port2LatchIn[3]) |-> !port2Oe[3])
        else $error("Forced open-drain pin driven high");

    a_nibble_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!memIf.active && stateReg.port4Latch[7]) |-> (port4Oe[7] == stateReg.nibbleMode[1]))
        else $error("Upper nibble mode not applied");

    a_pullup_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (port3Oe[1] && !port3Out[1]) |-> !port3PullupEn[1])
        else $error("Pull-up on while driving low");

    a_rmw_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfrReq.rdEn && sfrReq.rmwRead && sfrReq.addr == port_io_pkg::PORT3_LATCH_ADDR
         && !sfrReq.wrEn) |=> (sfrRdData == $past(stateReg.port3Latch)))
        else $error("Read-modify-write read not latch");

    a_mem_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (memIf.active && memIf.readCycle) |-> (port3Oe == 8'h00))
        else $error("Data bus driven during memory read");

    a_push_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!memIf.active && stateReg.port3Latch[5] && !port3ForceOd[5]) |-> (port3Oe[5] == stateReg.port3Mode[5]))
        else $error("Port3 mode bit not applied");

    a_port2_push: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (port2LatchIn[0] && !port2ForceOd[0]) |-> (port2Oe[0] == stateReg.port2Mode[0]))
        else $error("Port2 mode bit not applied");

    a_latch_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfrReq.wrEn && sfrReq.addr == port_io_pkg::PORT3_LATCH_ADDR)
        |=> (stateReg.port3Latch == $past(sfrReq.wrData)))
        else $error("Port3 latch write lost");

    a_pin_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfrReq.rdEn && !sfrReq.rmwRead && sfrReq.addr == port_io_pkg::PORT3_LATCH_ADDR)
        |=> (sfrRdData == $past(port3PinSync2)))
        else $error("Port3 read not pin levels");

    a_p4_pins: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfrReq.rdEn && !sfrReq.rmwRead && sfrReq.addr == port_io_pkg::PORT4_LATCH_ADDR)
        |=> (sfrRdData == $past(port4PinSync2)))
        else $error("Port4 read not pin levels");

    a_p4_rmw: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sfrReq.rdEn && sfrReq.rmwRead && sfrReq.addr == port_io_pkg::PORT4_LATCH_ADDR)
        |=> (sfrRdData == $past(stateReg.port4Latch)))
        else $error("Port4 read-modify-write read not latch");

    a_rise_b: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (stateReg.irqFlags[port_io_pkg::IRQ_B_POLARITY_BIT] && stateReg.sync2[1] && !stateReg.syncPrev[1])
        |=> edgeIrqB)
        else $error("Rising edge missed on interrupt B");

    a_pullup_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        stateReg.crossbar2[port_io_pkg::PULLUP_DISABLE_BIT] |-> ((port3PullupEn | port4PullupEn) == 8'h00))
        else $error("Pull-up on while globally disabled");

    a_mem_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (memIf.active && !memIf.readCycle) |-> (port3Out == memIf.dataOut))
        else $error("Memory byte not on port3");

    a_mem_strobe: assert property (@(posedge sys_clk) disable iff (!reset_n)
        memIf.active |-> (port4Out[port_io_pkg::MEM_WR_PIN] == memIf.wrStrobe
                          && port4Out[port_io_pkg::MEM_RD_PIN] == memIf.rdStrobe))
        else $error("Memory strobes not on port4");

    a_flag_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wrFlags && !sfrReq.wrData[port_io_pkg::IRQ_B_PENDING_BIT] && !edgeSeen[1]) |=> !edgeIrqB)
        else $error("Pending flag B not cleared by write");

    a_nibble_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!memIf.active && stateReg.port4Latch[0]) |-> (port4Oe[0] == stateReg.nibbleMode[0]))
        else $error("Lower nibble mode not applied");

    c_irq_b: cover property (@(posedge sys_clk) disable iff (!reset_n) edgeSeen[1]);
    c_clear: cover property (@(posedge sys_clk) disable iff (!reset_n) wrFlags ##1 !edgeIrqA);
    c_mem: cover property (@(posedge sys_clk) disable iff (!reset_n) memIf.active && memIf.readCycle);
    c_rmw: cover property (@(posedge sys_clk) disable iff (!reset_n) sfrReq.rdEn && sfrReq.rmwRead);
    c_rise_a: cover property (@(posedge sys_clk) disable iff (!reset_n)
        edgeSeen[0] && stateReg.irqFlags[port_io_pkg::IRQ_A_POLARITY_BIT]);
endmodule

// ==== inc/port_io_pkg.sv ====
// Package: register map, reset values and carrier types of the port block
package port_io_pkg;
    // Register offsets on the special-function-register bus
    localparam logic [7:0] PORT4_LATCH_ADDR      = 8'h84;
    localparam logic [7:0] PORT2_DRIVE_MODE_ADDR = 8'hA6;
    localparam logic [7:0] PORT3_DRIVE_MODE_ADDR = 8'hA7;
    localparam logic [7:0] EXT_IRQ_FLAGS_ADDR    = 8'hAD;
    localparam logic [7:0] PORT3_LATCH_ADDR      = 8'hB0;
    localparam logic [7:0] HIGH_NIBBLE_MODE_ADDR = 8'hB5;
    localparam logic [7:0] CROSSBAR_CTRL2_ADDR   = 8'hE3;

    // Reset values
    localparam logic [7:0] LATCH_RESET    = 8'hFF;
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam logic [7:0] CROSSBAR_RESET = 8'h00;

    // Field positions
    localparam int IRQ_B_PENDING_BIT  = 7;
    localparam int IRQ_A_PENDING_BIT  = 6;
    localparam int IRQ_B_POLARITY_BIT = 3;
    localparam int IRQ_A_POLARITY_BIT = 2;
    localparam int PULLUP_DISABLE_BIT = 7;
    localparam int LOW_STROBE_EN_BIT  = 1;
    localparam int IRQ_B_PIN          = 7;
    localparam int IRQ_A_PIN          = 6;
    localparam logic [7:0] FLAGS_IMPL_MASK = 8'hCC;

    // Memory interface strobe pins on the first high port
    localparam int MEM_WR_PIN  = 7;
    localparam int MEM_RD_PIN  = 6;
    localparam int MEM_ALE_PIN = 5;

    // Register bus request
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic       rmwRead;
        logic [7:0] addr;
        logic [7:0] wrData;
    } sfr_req_t;

    // External memory interface override for the data and strobe pins
    typedef struct packed {
        logic       active;
        logic       readCycle;
        logic [7:0] dataOut;
        logic       wrStrobe;
        logic       rdStrobe;
        logic       aleStrobe;
        logic       aleUsed;
    } mem_if_t;

    // All state of the block except the pin synchronisers
    typedef struct packed {
        logic [7:0] port2Mode;
        logic [7:0] port3Mode;
        logic [7:0] port3Latch;
        logic [7:0] port4Latch;
        logic [7:0] nibbleMode;
        logic [7:0] irqFlags;
        logic [7:0] crossbar2;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] syncPrev;
        logic [7:0] rdData;
    } port_state_t;
endpackage

// ==== dv/pin_board.sv ====
// Board model: resolves the level of one port's pins
`timescale 1ns/1ps
module pin_board (
    // Clock
    input  wire logic       clk,
    // Device side
    input  wire logic [7:0] devOut,
    input  wire logic [7:0] devOe,
    input  wire logic [7:0] pullEn,
    // Board side
    input  wire logic [7:0] extVal,
    input  wire logic [7:0] extEn,
    output logic      [7:0] pinLevel
);
    logic [7:0] floatPat = 8'h5A;

    // Undriven, unpulled pins wander so no stale level is read
    always @(posedge clk) begin
        floatPat <= ~floatPat;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (devOe[i])
                pinLevel[i] = devOut[i];
            else if (extEn[i])
                pinLevel[i] = extVal[i];
            else if (pullEn[i])
                pinLevel[i] = 1'b1;
            else
                pinLevel[i] = floatPat[i];
        end
    end
endmodule

// ==== dv/tb.sv ====
// Testbench: register rows, then reset, drive, pin read, edge flag and memory tests
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       rmw;
        logic [7:0] exp;
    } row_t;
    logic                  sys_clk;
    logic                  reset_n;
    port_io_pkg::sfr_req_t sfrReq;
    port_io_pkg::mem_if_t  memIf;
    logic [7:0]            sfrRdData, port2ForceOd, port3ForceOd, port2LatchIn;
    logic [7:0]            port2In, port2Out, port2Oe, port2PullupEn;
    logic [7:0]            port3In, port3Out, port3Oe, port3PullupEn;
    logic [7:0]            port4In, port4Out, port4Oe, port4PullupEn;
    logic [7:0]            ext3Val, ext3En, ext4Val, ext4En;
    logic                  edgeIrqA, edgeIrqB, lowPortStrobeEnable;
    int                    errorCnt = 0;
    int                    cmpCount = 0;
    row_t                  rows [8];

    port_io_banks port_io_banks_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
        .port2ForceOd(port2ForceOd), .port3ForceOd(port3ForceOd), .memIf(memIf),
        .port2In(port2In), .port2Out(port2Out), .port2Oe(port2Oe), .port2PullupEn(port2PullupEn),
        .port3In(port3In), .port3Out(port3Out), .port3Oe(port3Oe), .port3PullupEn(port3PullupEn),
        .port4In(port4In), .port4Out(port4Out), .port4Oe(port4Oe), .port4PullupEn(port4PullupEn),
        .edgeIrqA(edgeIrqA), .edgeIrqB(edgeIrqB), .lowPortStrobeEnable(lowPortStrobeEnable),
        .port2LatchIn(port2LatchIn)
    );
    pin_board board2 (.clk(sys_clk), .devOut(port2Out), .devOe(port2Oe), .pullEn(port2PullupEn),
                      .extVal(8'h00), .extEn(8'h00), .pinLevel(port2In));
    pin_board board3 (.clk(sys_clk), .devOut(port3Out), .devOe(port3Oe), .pullEn(port3PullupEn),
                      .extVal(ext3Val), .extEn(ext3En), .pinLevel(port3In));
    pin_board board4 (.clk(sys_clk), .devOut(port4Out), .devOe(port4Oe), .pullEn(port4PullupEn),
                      .extVal(ext4Val), .extEn(ext4En), .pinLevel(port4In));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfrReq.wrEn = 1'b1;
        sfrReq.addr = a;
        sfrReq.wrData = d;
        @(negedge sys_clk);
        sfrReq.wrEn = 1'b0;
    endtask
    // Read data is registered: taken at the negedge after the request edge
    task automatic rd_chk(input string what, input logic [7:0] a, input logic rmw, input logic [7:0] exp);
        @(negedge sys_clk);
        sfrReq.rdEn = 1'b1;
        sfrReq.rmwRead = rmw;
        sfrReq.addr = a;
        @(negedge sys_clk);
        chk_byte(what, exp, sfrRdData);
        sfrReq.rdEn = 1'b0;
        sfrReq.rmwRead = 1'b0;
    endtask
    task automatic do_reset;
        @(negedge sys_clk);
        reset_n = 1'b0;
        wait_cyc(5);
        reset_n = 1'b1;
    endtask
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Tests need about 140 cycles; allow some twenty times that
    initial begin
        #(3000 * 100);
        errorCnt++;
        complete_run();
    end

    initial begin
        reset_n = 1'b0;
        sfrReq = '0;
        memIf = '0;
        port2ForceOd = 8'h00;
        port3ForceOd = 8'h00;
        port2LatchIn = 8'hFF;
        ext3Val = 8'hFF;
        ext3En = 8'h00;
        ext4Val = 8'hFF;
        ext4En = 8'h00;
        rows = '{'{8'hA6, 8'hA5, 1'b0, 8'hA5}, '{8'hA7, 8'h3C, 1'b0, 8'h3C}, '{8'hB5, 8'h96, 1'b0, 8'h96},
                 '{8'hAD, 8'h3C, 1'b0, 8'h0C}, '{8'h55, 8'hFF, 1'b0, 8'h00}, '{8'hB0, 8'h5A, 1'b1, 8'h5A},
                 '{8'h84, 8'hC3, 1'b1, 8'hC3}, '{8'hE3, 8'h02, 1'b0, 8'h02}};
        do_reset();
        foreach (rows[i]) begin
            sfr_wr(rows[i].addr, rows[i].data);
            rd_chk($sformatf("row%0d", i), rows[i].addr, rows[i].rmw, rows[i].exp);
        end
        chk_bit("lowStrobe", 1'b1, lowPortStrobeEnable);
        $display("Test register rows done");

        do_reset();
        foreach (rows[i]) begin
            if (i < 4 || i == 7)
                rd_chk($sformatf("rst%0d", i), rows[i].addr, 1'b0, 8'h00);
        end
        rd_chk("rstP3", 8'hB0, 1'b1, port_io_pkg::LATCH_RESET);
        rd_chk("rstP4", 8'h84, 1'b1, port_io_pkg::LATCH_RESET);
        chk_byte("rstOe3", 8'h00, port3Oe);
        chk_byte("rstOe4", 8'h00, port4Oe);
        chk_byte("rstPu3", 8'hFF, port3PullupEn);
        chk_byte("rstPu4", 8'hFF, port4PullupEn);
        $display("Test reset done");

        sfr_wr(8'hA7, 8'h0F);
        sfr_wr(8'hB0, 8'h55);
        chk_byte("p3Oe", 8'hAF, port3Oe);
        chk_byte("p3Out", 8'h05, port3Out & port3Oe);
        chk_byte("p3Pu", 8'h55, port3PullupEn);
        port3ForceOd = 8'h01;
        wait_cyc(1);
        chk_byte("p3Force", 8'hAE, port3Oe);
        port2LatchIn = 8'h3C;
        sfr_wr(8'hA6, 8'h0F);
        chk_byte("p2Oe", 8'hCF, port2Oe);
        port2ForceOd = 8'h0C;
        wait_cyc(1);
        chk_byte("p2Force", 8'hC3, port2Oe);
        chk_byte("p2Out", 8'h3C, port2Out);
        chk_byte("p2Pu", 8'h3C, port2PullupEn);
        $display("Test low drive done");

        sfr_wr(8'hB5, 8'h02);
        sfr_wr(8'h84, 8'h3C);
        chk_byte("p4OeHi", 8'hF3, port4Oe);
        chk_byte("p4Out", 8'h30, port4Out & port4Oe);
        sfr_wr(8'hB5, 8'h01);
        chk_byte("p4OeLo", 8'hCF, port4Oe);
        sfr_wr(8'hB5, 8'hFC);
        chk_byte("p4OeOther", 8'hC3, port4Oe);
        sfr_wr(8'hB5, 8'hFF);
        chk_byte("p4OeAll", 8'hFF, port4Oe);
        $display("Test nibble drive done");

        // Software makes all port3 and port4 pins inputs: open-drain and latch one
        port3ForceOd = 8'h00;
        sfr_wr(8'hA7, 8'h00);
        sfr_wr(8'hB0, 8'hFF);
        sfr_wr(8'hB5, 8'h00);
        sfr_wr(8'h84, 8'hFF);
        ext3Val = 8'hA5;
        ext3En = 8'hFF;
        ext4Val = 8'h96;
        ext4En = 8'hFF;
        wait_cyc(4);
        rd_chk("p3Pins", 8'hB0, 1'b0, 8'hA5);
        rd_chk("p3Rmw", 8'hB0, 1'b1, 8'hFF);
        rd_chk("p4Pins", 8'h84, 1'b0, 8'h96);
        $display("Test pin read done");

        ext3Val = 8'hFF;
        wait_cyc(6);
        sfr_wr(8'hAD, 8'h00);
        rd_chk("flagsClr", 8'hAD, 1'b0, 8'h00);
        ext3Val[7] = 1'b0;
        wait_cyc(6);
        chk_bit("irqBFall", 1'b1, edgeIrqB);
        chk_bit("irqAIdle", 1'b0, edgeIrqA);
        rd_chk("flagsB", 8'hAD, 1'b0, 8'h80);
        sfr_wr(8'hAD, 8'h84);
        ext3Val[6] = 1'b0;
        wait_cyc(6);
        chk_bit("irqAFall", 1'b0, edgeIrqA);
        ext3Val[6] = 1'b1;
        ext3Val[7] = 1'b1;
        wait_cyc(6);
        chk_bit("irqARise", 1'b1, edgeIrqA);
        rd_chk("flagsBoth", 8'hAD, 1'b0, 8'hC4);
        sfr_wr(8'hAD, 8'h00);
        chk_bit("irqAClr", 1'b0, edgeIrqA);
        chk_bit("irqBClr", 1'b0, edgeIrqB);
        $display("Test edge flags done");

        sfr_wr(8'hE3, 8'h80);
        chk_byte("pu3Off", 8'h00, port3PullupEn);
        chk_byte("pu4Off", 8'h00, port4PullupEn);
        sfr_wr(8'hE3, 8'h00);
        chk_byte("pu3On", 8'hFF, port3PullupEn);
        $display("Test pull-ups done");

        // Memory drives the byte on port3 and strobes on port4; reads release port3
        ext3En = 8'h00;
        ext4En = 8'h00;
        sfr_wr(8'hA7, 8'hFF);
        sfr_wr(8'hB5, 8'h02);
        memIf = '{active: 1'b1, readCycle: 1'b0, dataOut: 8'h3C, wrStrobe: 1'b0, rdStrobe: 1'b1,
                  aleStrobe: 1'b1, aleUsed: 1'b1};
        wait_cyc(1);
        chk_byte("memOe", 8'hFF, port3Oe);
        chk_byte("memData", 8'h3C, port3Out);
        chk_byte("memStrobe", 8'h03, {5'h00, port4Out[7:5]});
        memIf.readCycle = 1'b1;
        wait_cyc(1);
        chk_byte("memRdOe", 8'h00, port3Oe);
        memIf = '0;
        wait_cyc(1);
        chk_byte("memOff", 8'hFF, port3Out & port3Oe);
        $display("Test memory override done");
        complete_run();
    end
endmodule
